// File: src/vtsev_counter.sv
`default_nettype none
module vtsev_counter #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Control
	input wire logic inc_i,
	input wire logic clr_i,
	// Value
	output logic [W-1:0] count_o
);
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_o <= '0;
		end else if (clr_i) begin
			// An occurrence in the clearing cycle is still counted
			count_o <= inc_i ? {{(W-1){1'b0}}, 1'b1} : '0;
		end else if (inc_i && !(&count_o)) begin
			count_o <= count_o + 1'b1;
		end
	end

	a_clear_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		clr_i && !inc_i |=> count_o == '0)
		else $error("counter not zero after clear");
	a_count_step: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		inc_i && !clr_i && !(&count_o) |=> count_o == $past(count_o) + 1'b1)
		else $error("counter missed an occurrence");
endmodule : vtsev_counter
`default_nettype wire

// File: src/vtsev_map.svh
`ifndef VTSEV_MAP_SVH
`define VTSEV_MAP_SVH

// Clock and program cycle
`define VTSEV_CLK_KHZ 40000
`define VTSEV_CYCLE_MS 5
// Longest operate delay in program-cycle steps (1800 s / 5 ms)
`define VTSEV_DELAY_MAX 19'h57e40
`define VTSEV_REC_DEPTH 12
`define VTSEV_N_SRC 6
`define VTSEV_N_EV 12

// Event sources, event code is source * 2 plus one for the off edge
`define VTSEV_SRC_START 0
`define VTSEV_SRC_TRIP 1
`define VTSEV_SRC_BLOCK 2
`define VTSEV_SRC_LINE 3
`define VTSEV_SRC_BFUSE 4
`define VTSEV_SRC_LFUSE 5

// Register byte offsets
`define VTSEV_OFS_MODE 8'h00
`define VTSEV_OFS_DELAY 8'h04
`define VTSEV_OFS_EVSEL 8'h08
`define VTSEV_OFS_CNTCLR 8'h0c
`define VTSEV_OFS_STATUS 8'h10
`define VTSEV_OFS_REMAIN 8'h14
`define VTSEV_OFS_CNT_START 8'h18
`define VTSEV_OFS_CNT_BUS 8'h1c
`define VTSEV_OFS_CNT_LINE 8'h20
`define VTSEV_OFS_CNT_BLOCK 8'h24
`define VTSEV_OFS_REC_SEL 8'h28
`define VTSEV_OFS_REC_TS_LO 8'h2c
`define VTSEV_OFS_REC_TS_HI 8'h30
`define VTSEV_OFS_REC_INFO 8'h34
`define VTSEV_OFS_REC_ANG_AB 8'h38
`define VTSEV_OFS_REC_ANG_CD 8'h3c
`define VTSEV_OFS_REC_REMAIN 8'h40

// Reset values
`define VTSEV_MODE_RST 3'h0
`define VTSEV_DELAY_RST 19'h000c8
`define VTSEV_EVSEL_RST 12'hfff

`endif

// File: src/vtsev_pkg.sv
`default_nettype none
package vtsev_pkg;
	typedef enum logic [2:0] {
		VTSEV_MODE_ON, VTSEV_MODE_BLOCKED, VTSEV_MODE_TEST,
		VTSEV_MODE_TEST_BLOCKED, VTSEV_MODE_OFF
	} vtsev_mode_type;
	typedef enum logic [2:0] {
		VTSEV_COND_NORMAL, VTSEV_COND_START,
		VTSEV_COND_LINE_FAIL, VTSEV_COND_BUS_FAIL, VTSEV_COND_BLOCKED
	} vtsev_cond_type;
	typedef enum logic [2:0] {
		VTSEV_BUS_DEAD, VTSEV_BUS_OK_SEQ_OK, VTSEV_BUS_OK_SEQ_REV,
		VTSEV_BUS_OK_SEQ_UNDEF, VTSEV_BUS_FAULT
	} vtsev_bus_type;
	typedef enum logic [1:0] {
		VTSEV_VOLT_NONE, VTSEV_VOLT_OK, VTSEV_VOLT_LOW
	} vtsev_volt_type;
endpackage : vtsev_pkg
`default_nettype wire

// File: src/vtsev_top.sv
`include "vtsev_map.svh"
`default_nettype none
// How it works
// - Blocking input sampled at each cycle start
// - Pick-up unblocked gives start and timing
// - Pick-up while blocked gives blocked only
// - Blocking drops start, releases like pick-up
// - Definite-time delay from start to alarm
// - Per-event selection of on/off edges
// - Every event carries its time stamp
// - Four resettable occurrence counters
// - Ring of twelve newest records
// - Records captured on on-edges only
// - Record holds four voltage channel statuses
// - Five-state system status, live and recorded
// - Record holds four angle differences
// - Live condition state of five values
// - Remaining time published in 5 ms steps
// - Expected operating time published
// - On and off events for six sources
// - Operating mode reported, five values
// - Status available as plain binary outputs
// - Pick-up: one low or two high
module vtsev_top import vtsev_pkg::*; #(
	parameter int TIME_W = 19,
	parameter int CNT_W = 16,
	parameter int CYCLE_CLKS = `VTSEV_CYCLE_MS * `VTSEV_CLK_KHZ
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Measurement and blocking
	input wire logic [2:0] phase_low_i,
	input wire logic [2:0] phase_high_i,
	input wire logic block_i,
	input wire logic line_fail_i,
	input wire logic bus_fuse_fail_i,
	input wire logic line_fuse_fail_i,
	input wire logic [7:0] volt_status_i,
	input wire logic [1:0] seq_i,
	input wire logic [63:0] angle_diff_i,
	input wire logic [47:0] timestamp_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_stb_i,
	input wire logic rd_stb_i,
	output logic [31:0] rdata_o,
	// Status outputs
	output logic start_o,
	output logic blocked_o,
	output logic bus_alarm_o,
	output logic line_alarm_o,
	output vtsev_cond_type cond_o,
	output vtsev_bus_type bus_status_o,
	output vtsev_mode_type mode_o,
	output logic [TIME_W-1:0] remain_o,
	output logic [TIME_W-1:0] expected_o,
	// Event stream
	output logic ev_valid_o,
	output logic [3:0] ev_code_o,
	output logic [47:0] ev_stamp_o
);
	localparam int NS = `VTSEV_N_SRC;
	localparam int NE = `VTSEV_N_EV;
	localparam int RD = `VTSEV_REC_DEPTH;

	logic [31:0] cyc_cnt;
	logic tick;
	logic [2:0] mode_reg;
	logic [TIME_W-1:0] delay_reg;
	logic [NE-1:0] evsel;
	logic [3:0] cnt_clr;
	logic [3:0] rec_sel;
	logic start_q, trip_q, blocked_q, line_q, bfuse_q, lfuse_q;
	logic [TIME_W-1:0] remain;
	logic [NS-1:0] stat, stat_d, on_edge, off_edge;
	logic [NE-1:0] pend, req, grant;
	logic [47:0] ts_q;
	logic active, blk_now, pickup, pick, next_start;
	logic [TIME_W-1:0] next_remain;
	vtsev_mode_type mode;
	vtsev_bus_type bus_now;
	logic [3:0] wr_ptr, rec_count, rec_code;
	logic rec_we;
	logic [47:0] rec_ts [RD];
	logic [14:0] rec_info [RD];
	logic [63:0] rec_ang [RD];
	logic [TIME_W-1:0] rec_rem [RD];
	logic [CNT_W-1:0] cnt_start, cnt_bus, cnt_line, cnt_block;

	// Program cycle tick
	assign tick = (cyc_cnt == 32'(CYCLE_CLKS - 1));
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cyc_cnt <= '0;
		end else if (tick) begin
			cyc_cnt <= '0;
		end else begin
			cyc_cnt <= cyc_cnt + 32'h1;
		end
	end

	// Register writes
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= `VTSEV_MODE_RST;
			delay_reg <= `VTSEV_DELAY_RST;
			evsel <= `VTSEV_EVSEL_RST;
			rec_sel <= 4'h0;
		end else if (wr_stb_i) begin
			case (addr_i)
				`VTSEV_OFS_MODE: mode_reg <= wdata_i[2:0];
				`VTSEV_OFS_DELAY: begin
					// Clamp to the longest operate delay, 1800 s in program-cycle steps
					if (wdata_i[TIME_W-1:0] > `VTSEV_DELAY_MAX) begin
						delay_reg <= `VTSEV_DELAY_MAX;
					end else begin
						delay_reg <= wdata_i[TIME_W-1:0];
					end
				end
				`VTSEV_OFS_EVSEL: evsel <= wdata_i[NE-1:0];
				`VTSEV_OFS_REC_SEL: rec_sel <= wdata_i[3:0];
				default: ;
			endcase
		end
	end
	assign cnt_clr = (wr_stb_i && addr_i == `VTSEV_OFS_CNTCLR) ?
		wdata_i[3:0] : 4'h0;

	// Mode decode; unknown codes behave as off
	always_comb begin
		case (mode_reg)
			3'h0: mode = VTSEV_MODE_ON;
			3'h1: mode = VTSEV_MODE_BLOCKED;
			3'h2: mode = VTSEV_MODE_TEST;
			3'h3: mode = VTSEV_MODE_TEST_BLOCKED;
			default: mode = VTSEV_MODE_OFF;
		endcase
	end
	assign mode_o = mode;

	// Per-cycle decision
	assign active = (mode != VTSEV_MODE_OFF);
	assign blk_now = block_i || mode == VTSEV_MODE_BLOCKED ||
		mode == VTSEV_MODE_TEST_BLOCKED;
	assign pickup = (|phase_low_i) || (phase_high_i[0] && phase_high_i[1]) ||
		(phase_high_i[0] && phase_high_i[2]) ||
		(phase_high_i[1] && phase_high_i[2]);
	assign pick = active && pickup;
	assign next_start = pick && !blk_now;
	always_comb begin
		if (!next_start) begin
			next_remain = '0;
		end else if (!start_q) begin
			next_remain = delay_reg;
		end else if (remain != '0) begin
			next_remain = remain - 1'b1;
		end else begin
			next_remain = '0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			start_q <= 1'b0;
			trip_q <= 1'b0;
			blocked_q <= 1'b0;
			line_q <= 1'b0;
			bfuse_q <= 1'b0;
			lfuse_q <= 1'b0;
			remain <= '0;
			ts_q <= '0;
		end else if (tick) begin
			// Blocking during start drops it like a lost pick-up
			start_q <= next_start;
			trip_q <= next_start && next_remain == '0;
			blocked_q <= pick && blk_now;
			line_q <= active && !blk_now && line_fail_i;
			bfuse_q <= active && bus_fuse_fail_i;
			lfuse_q <= active && line_fuse_fail_i;
			remain <= next_remain;
			ts_q <= timestamp_i;
		end
	end

	// Live bus status
	always_comb begin
		if (volt_status_i == 8'h00) begin
			bus_now = VTSEV_BUS_DEAD;
		end else if (pickup) begin
			bus_now = VTSEV_BUS_FAULT;
		end else begin
			case (seq_i)
				2'h0: bus_now = VTSEV_BUS_OK_SEQ_OK;
				2'h1: bus_now = VTSEV_BUS_OK_SEQ_REV;
				default: bus_now = VTSEV_BUS_OK_SEQ_UNDEF;
			endcase
		end
	end

	// Published status, all from flip-flops
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cond_o <= VTSEV_COND_NORMAL;
			bus_status_o <= VTSEV_BUS_DEAD;
			expected_o <= '0;
		end else begin
			bus_status_o <= bus_now;
			expected_o <= delay_reg;
			if (blocked_q) begin
				cond_o <= VTSEV_COND_BLOCKED;
			end else if (trip_q) begin
				cond_o <= VTSEV_COND_BUS_FAIL;
			end else if (line_q) begin
				cond_o <= VTSEV_COND_LINE_FAIL;
			end else if (start_q) begin
				cond_o <= VTSEV_COND_START;
			end else begin
				cond_o <= VTSEV_COND_NORMAL;
			end
		end
	end
	assign start_o = start_q;
	assign blocked_o = blocked_q;
	assign bus_alarm_o = trip_q;
	assign line_alarm_o = line_q;
	assign remain_o = remain;

	// Edge detection of the six event sources
	assign stat = {lfuse_q, bfuse_q, line_q, blocked_q, trip_q, start_q};
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_d <= '0;
		end else begin
			stat_d <= stat;
		end
	end
	assign on_edge = stat & ~stat_d;
	assign off_edge = ~stat & stat_d;
	always_comb begin
		req = '0;
		for (int i = 0; i < NS; i++) begin
			req[2*i] = on_edge[i] && evsel[2*i];
			req[2*i+1] = off_edge[i] && evsel[2*i+1];
		end
	end

	// Pending events drain lowest code first, one per clock. All edges of
	// one program cycle share its stamp; draining takes far less than a cycle.
	assign grant = pend & (~pend + 12'h001);
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend <= '0;
		end else begin
			pend <= (pend & ~grant) | req;
		end
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ev_valid_o <= 1'b0;
			ev_code_o <= 4'h0;
			ev_stamp_o <= '0;
		end else begin
			ev_valid_o <= |grant;
			ev_stamp_o <= ts_q;
			ev_code_o <= 4'h0;
			for (int i = 0; i < NE; i++) begin
				if (grant[i]) begin
					ev_code_o <= 4'(i);
				end
			end
		end
	end

	// Record ring
	assign rec_we = |on_edge;
	always_comb begin
		rec_code = 4'h0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (on_edge[i]) begin
				rec_code = 4'(2 * i);
			end
		end
	end
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= 4'h0;
			rec_count <= 4'h0;
		end else if (rec_we) begin
			// Oldest entry is overwritten once the ring is full
			wr_ptr <= (wr_ptr == 4'(RD - 1)) ? 4'h0 : wr_ptr + 4'h1;
			if (rec_count != 4'(RD)) begin
				rec_count <= rec_count + 4'h1;
			end
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (rec_we) begin
			rec_ts[wr_ptr] <= ts_q;
			rec_info[wr_ptr] <= {bus_now, volt_status_i, rec_code};
			rec_ang[wr_ptr] <= angle_diff_i;
			rec_rem[wr_ptr] <= remain;
		end
	end

	// Occurrence counters
	vtsev_counter #(.W(CNT_W)) u_cnt_start (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .inc_i(on_edge[`VTSEV_SRC_START]),
		.clr_i(cnt_clr[0]), .count_o(cnt_start));
	vtsev_counter #(.W(CNT_W)) u_cnt_bus (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .inc_i(on_edge[`VTSEV_SRC_TRIP]),
		.clr_i(cnt_clr[1]), .count_o(cnt_bus));
	vtsev_counter #(.W(CNT_W)) u_cnt_line (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .inc_i(on_edge[`VTSEV_SRC_LINE]),
		.clr_i(cnt_clr[2]), .count_o(cnt_line));
	vtsev_counter #(.W(CNT_W)) u_cnt_block (.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i), .inc_i(on_edge[`VTSEV_SRC_BLOCK]),
		.clr_i(cnt_clr[3]), .count_o(cnt_block));

	// Register reads, data in the cycle after the strobe only
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= '0;
		end else if (!rd_stb_i) begin
			rdata_o <= '0;
		end else begin
			case (addr_i)
				`VTSEV_OFS_MODE: rdata_o <= 32'(mode_reg);
				`VTSEV_OFS_DELAY: rdata_o <= 32'(delay_reg);
				`VTSEV_OFS_EVSEL: rdata_o <= 32'(evsel);
				`VTSEV_OFS_STATUS: rdata_o <= 32'({bus_status_o, cond_o, stat});
				`VTSEV_OFS_REMAIN: rdata_o <= 32'(remain);
				`VTSEV_OFS_CNT_START: rdata_o <= 32'(cnt_start);
				`VTSEV_OFS_CNT_BUS: rdata_o <= 32'(cnt_bus);
				`VTSEV_OFS_CNT_LINE: rdata_o <= 32'(cnt_line);
				`VTSEV_OFS_CNT_BLOCK: rdata_o <= 32'(cnt_block);
				`VTSEV_OFS_REC_SEL: rdata_o <= 32'({wr_ptr, rec_count, rec_sel});
				default: rdata_o <= '0;
			endcase
			if (rec_sel < 4'(RD)) begin
				case (addr_i)
					`VTSEV_OFS_REC_TS_LO: rdata_o <= rec_ts[rec_sel][31:0];
					`VTSEV_OFS_REC_TS_HI: rdata_o <= 32'(rec_ts[rec_sel][47:32]);
					`VTSEV_OFS_REC_INFO: rdata_o <= 32'(rec_info[rec_sel]);
					`VTSEV_OFS_REC_ANG_AB: rdata_o <= rec_ang[rec_sel][31:0];
					`VTSEV_OFS_REC_ANG_CD: rdata_o <= rec_ang[rec_sel][63:32];
					`VTSEV_OFS_REC_REMAIN: rdata_o <= 32'(rec_rem[rec_sel]);
					default: ;
				endcase
			end
		end
	end

	a_status_on_tick: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!$past(tick) |-> $stable(stat))
		else $error("status changed outside a program cycle");
	a_start_unblocked: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		tick && pick && !blk_now |=> start_q)
		else $error("start missing on unblocked pick-up");
	a_blocked_no_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		tick && pick && blk_now |=> blocked_q && !start_q && !trip_q)
		else $error("blocked pick-up still started");
	a_block_drops_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		tick && start_q && blk_now |=> !start_q && remain == '0)
		else $error("start held while blocked");
	a_trip_needs_start: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		trip_q |-> start_q && remain == '0)
		else $error("alarm without expired start");
	a_remain_step: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		tick && start_q && next_start && remain != '0 |=>
		remain == $past(remain) - 1'b1)
		else $error("remaining time did not step");
	a_event_select: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		|req |-> ##2 ev_valid_o)
		else $error("selected event not emitted");
	a_event_stamp: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ev_valid_o |-> ev_stamp_o == ts_q)
		else $error("event stamp mismatch");
	a_ring_wrap: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		rec_we && wr_ptr == 4'(RD - 1) |=> wr_ptr == 4'h0)
		else $error("record ring did not wrap");
endmodule : vtsev_top
`default_nettype wire

// File: test/vtsev_partner.sv
`default_nettype none
module vtsev_partner (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Bench control
	input wire logic block_req_i,
	input wire logic clr_i,
	// Block side
	input wire logic ev_valid_i,
	input wire logic [3:0] ev_code_i,
	input wire logic [47:0] ev_stamp_i,
	output logic block_o,
	output logic [47:0] ts_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] seen;
	logic [47:0] stamp [16];
	// Matrix output is registered, so a request lands one clock late
	always @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			block_o <= 1'b0;
			ts_o <= 48'h0;
		end else begin
			block_o <= block_req_i;
			ts_o <= ts_o + 48'h1;
		end
	end
	// Event buffer keeps the last stamp of every code
	always @(posedge clk_sys_i) begin
		if (clr_i) begin
			seen <= 16'h0;
		end else if (ev_valid_i) begin
			seen[ev_code_i] <= 1'b1;
			stamp[ev_code_i] <= ev_stamp_i;
		end
	end
endmodule // vtsev_partner
`default_nettype wire

// File: test/vtsev_top_tb.sv
`default_nettype none
module vtsev_top_tb import vtsev_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CYC = 20;
	logic clk_sys_i, arst_n_i, blk_req, ev_clr;
	logic [2:0] phase_low_i, phase_high_i;
	logic block_i, line_fail_i, bus_fuse_fail_i, line_fuse_fail_i;
	logic [7:0] volt_status_i, addr_i;
	logic [1:0] seq_i;
	logic [63:0] angle_diff_i;
	logic [47:0] timestamp_i, ev_stamp_o;
	logic [31:0] wdata_i, rdata_o, rd;
	logic wr_stb_i, rd_stb_i, start_o, blocked_o, bus_alarm_o, line_alarm_o;
	vtsev_cond_type cond_o;
	vtsev_bus_type bus_status_o;
	vtsev_mode_type mode_o;
	logic [18:0] remain_o, expected_o;
	logic ev_valid_o;
	logic [3:0] ev_code_o;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	vtsev_top #(.CYCLE_CLKS(CYC)) dut (.clk_sys_i, .arst_n_i, .phase_low_i,
		.phase_high_i, .block_i, .line_fail_i, .bus_fuse_fail_i,
		.line_fuse_fail_i, .volt_status_i, .seq_i, .angle_diff_i,
		.timestamp_i, .addr_i, .wdata_i, .wr_stb_i, .rd_stb_i, .rdata_o,
		.start_o, .blocked_o, .bus_alarm_o, .line_alarm_o, .cond_o,
		.bus_status_o, .mode_o, .remain_o, .expected_o, .ev_valid_o,
		.ev_code_o, .ev_stamp_o);
	vtsev_partner pm (.clk_sys_i, .arst_n_i, .block_req_i(blk_req),
		.clr_i(ev_clr), .ev_valid_i(ev_valid_o), .ev_code_i(ev_code_o),
		.ev_stamp_i(ev_stamp_o), .block_o(block_i), .ts_o(timestamp_i));

	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end

	task automatic final_report;
		$display("Checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			$display("BAD %0t run did not finish", $time);
			final_report;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Settle past the edge so register updates have landed
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_stb_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_stb_i <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_stb_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_stb_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic wait_start;
		for (int i = 0; i < 2 * CYC && start_o !== 1'b1; i++) step(1);
	endtask

	task automatic t_regs;
		rd_reg(8'h04, rd);
		chk(rd, 32'hc8, "delay reset");
		rd_reg(8'h08, rd);
		chk(rd, 32'hfff, "evsel reset");
		rd_reg(8'hfc, rd);
		chk(rd, 32'h0, "unmapped read");
		wr_reg(8'h04, 32'h7ffff);
		step(1);
		chk(expected_o, 32'h57e40, "delay clamp");
		for (int m = 0; m < 5; m++) begin
			wr_reg(8'h00, m);
			step(1);
			chk(mode_o, m, "mode");
		end
		wr_reg(8'h00, 32'h0);
		seq_i <= 2'h1;
		step(CYC + 2);
		chk(bus_status_o, VTSEV_BUS_OK_SEQ_REV, "reversed seq");
		@(posedge clk_sys_i);
		seq_i <= 2'h0;
	endtask

	task automatic t_trip;
		wr_reg(8'h04, 32'h2);
		ev_clr <= 1'b1;
		@(posedge clk_sys_i);
		ev_clr <= 1'b0;
		phase_low_i <= 3'h1;
		wait_start;
		chk(remain_o, 32'h2, "remain first");
		step(1);
		chk(cond_o, VTSEV_COND_START, "cond start");
		step(CYC - 1);
		chk({bus_alarm_o, remain_o}, 32'h1, "one step left");
		step(CYC);
		chk({start_o, bus_alarm_o}, 2'h3, "trip");
		chk(remain_o, 32'h0, "remain end");
		step(16);
		chk(pm.seen[3:0], 4'h5, "on events");
		chk(32'(pm.stamp[2] - pm.stamp[0]), 2 * CYC, "stamps");
		rd_reg(8'h18, rd);
		chk(rd, 32'h1, "start count");
		rd_reg(8'h1c, rd);
		chk(rd, 32'h1, "bus count");
		rd_reg(8'h28, rd);
		chk(rd[11:4], 8'h22, "ring fill");
		wr_reg(8'h28, 32'h1);
		rd_reg(8'h34, rd);
		chk(rd[14:0], 15'h4552, "record info");
		rd_reg(8'h38, rd);
		chk(rd, angle_diff_i[31:0], "angles");
	endtask

	task automatic t_evsel;
		wr_reg(8'h08, 32'hffd);
		ev_clr <= 1'b1;
		@(posedge clk_sys_i);
		ev_clr <= 1'b0;
		phase_low_i <= 3'h0;
		step(CYC + 16);
		chk(start_o, 1'b0, "pickup lost");
		chk(pm.seen[3:0], 4'h8, "off filter");
		rd_reg(8'h28, rd);
		chk(rd[11:4], 8'h22, "no off record");
		wr_reg(8'h08, 32'hfff);
	endtask

	task automatic t_block;
		wr_reg(8'h04, 32'h4);
		phase_high_i <= 3'h6;
		wait_start;
		chk(start_o, 1'b1, "two high pickup");
		blk_req <= 1'b1;
		step(CYC - 2);
		chk(start_o, 1'b1, "block waits cycle");
		step(2);
		chk({start_o, blocked_o, remain_o}, 32'h80000, "block drops");
		step(1);
		chk(cond_o, VTSEV_COND_BLOCKED, "cond blocked");
		step(4 * CYC);
		chk({start_o, bus_alarm_o, blocked_o}, 3'h1, "no trip");
		rd_reg(8'h24, rd);
		chk(rd, 32'h1, "block count");
		wr_reg(8'h0c, 32'h1);
		rd_reg(8'h18, rd);
		chk(rd, 32'h0, "start cleared");
		rd_reg(8'h24, rd);
		chk(rd, 32'h1, "block kept");
		@(posedge clk_sys_i);
		phase_high_i <= 3'h0;
		blk_req <= 1'b0;
		step(CYC + 2);
		chk(blocked_o, 1'b0, "unblocked");
	endtask

	task automatic t_modes;
		wr_reg(8'h00, 32'h4);
		phase_low_i <= 3'h2;
		step(CYC + 2);
		chk({start_o, cond_o}, 4'h0, "off mode");
		wr_reg(8'h00, 32'h1);
		step(CYC + 2);
		chk({start_o, blocked_o}, 2'h1, "blocked mode");
		wr_reg(8'h00, 32'h0);
		phase_low_i <= 3'h0;
	endtask

	// Seven more on-edges carry the ring past its twelfth slot
	task automatic t_ring;
		line_fail_i <= 1'b1;
		bus_fuse_fail_i <= 1'b1;
		step(CYC + 2);
		chk(line_alarm_o, 1'b1, "line alarm");
		chk(cond_o, VTSEV_COND_LINE_FAIL, "cond line");
		rd_reg(8'h20, rd);
		chk(rd, 32'h1, "line count");
		for (int k = 0; k < 7; k++) begin
			@(posedge clk_sys_i);
			line_fuse_fail_i <= 1'b1;
			repeat (CYC) @(posedge clk_sys_i);
			line_fuse_fail_i <= 1'b0;
			repeat (CYC - 1) @(posedge clk_sys_i);
		end
		rd_reg(8'h28, rd);
		chk(rd[11:4], 8'h1c, "ring wrap");
		wr_reg(8'h28, 32'h0);
		rd_reg(8'h34, rd);
		chk(rd[14:0], 15'h155a, "newest record");
	endtask

	initial begin
		arst_n_i = 1'b0;
		blk_req = 1'b0;
		ev_clr = 1'b1;
		phase_low_i = 3'h0;
		phase_high_i = 3'h0;
		line_fail_i = 1'b0;
		bus_fuse_fail_i = 1'b0;
		line_fuse_fail_i = 1'b0;
		volt_status_i = 8'h55;
		seq_i = 2'h0;
		angle_diff_i = 64'h0000_1000_2000_3000;
		addr_i = 8'h0;
		wdata_i = 32'h0;
		wr_stb_i = 1'b0;
		rd_stb_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		t_regs;
		t_trip;
		t_evsel;
		t_block;
		t_modes;
		t_ring;
		final_report;
	end
endmodule // vtsev_top_tb
`default_nettype wire
